// >>> rtl/automute_gain_eeprom_boot_cfg_consts.svh
`ifndef AUTOMUTE_GAIN_EEPROM_BOOT_CFG_CONSTS_SVH
`define AUTOMUTE_GAIN_EEPROM_BOOT_CFG_CONSTS_SVH
// ----------------------------------------
// Register indexes (byte address = 4 * index)
// ----------------------------------------
`define IDX_MUTE_CTRL 8'h50
`define IDX_MUTE_TIME 8'h51
`define IDX_ANA_LOOP 8'h53
`define IDX_GAIN 8'h54
`define IDX_SCK_SEL 8'h55
`define IDX_BOOT_CTRL 8'h56
`define IDX_READ_CMD 8'h57
`define IDX_ADDR_HIGH 8'h58
`define IDX_ADDR_MID 8'h59
`define IDX_ADDR_LOW 8'h5a
`define IDX_BOOT_STAT 8'h5b
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_MUTE_CTRL 8'h07
`define RST_READ_CMD 8'h03
`define RST_ZERO 8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define POS_LEFT_TIME 4
`define POS_RIGHT_TIME 0
`define POS_LOOP_BW 5
`define POS_PHASE 0
`define POS_WIDE_ADDR 5
`define POS_SCK_RATE 3
`define POS_EDGE_SEL 2
`define POS_BIT_ORDER 1
`define POS_BOOT_SRC 0
`define POS_MUTE_LINK 2
// ----------------------------------------
// Timing: zero-run lengths in microseconds, converted to samples at 96 kHz
// ----------------------------------------
`define SAMPLE_RATE_HZ 96000
`define ZR_US_0 11500
`define ZR_US_1 53000
`define ZR_US_2 106500
`define ZR_US_3 266500
`define ZR_US_4 535000
`define ZR_US_5 1065000
`define ZR_US_6 2665000
`define ZR_US_7 5330000
`define MCLK_HZ 10000000
`define SCK_HZ_0 1250000
`define SCK_HZ_1 2500000
`define SCK_HZ_2 5000000
`define SCK_HZ_3 10000000
`endif

// >>> rtl/automute_gain_eeprom_boot_cfg_pkg.sv
package automute_gain_eeprom_boot_cfg_pkg;
  // Boot master states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LAUNCH = 4'b0010,
    ST_SAMPLE = 4'b0100,
    ST_FINISH = 4'b1000
  } boot_state_t;
  // One stereo audio sample
  typedef struct packed {
    logic valid;
    logic [23:0] left;
    logic [23:0] right;
  } stereo_sample_t;
  // Serial master pins toward the boot memory
  typedef struct packed {
    logic sck;
    logic mosi;
    logic cs_n;
  } serial_out_t;
endpackage

// >>> rtl/automute_gain_eeprom_boot_cfg.sv
`timescale 1ns/1ps
`default_nettype none
`include "automute_gain_eeprom_boot_cfg_consts.svh"

module automute_gain_eeprom_boot_cfg
  import automute_gain_eeprom_boot_cfg_pkg::*;
#(
  parameter int BOOT_BYTES = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Audio samples and mute results
  input wire stereo_sample_t audio_in,
  output logic [1:0] chan_muted,
  // Analog settings
  output logic [7:0] loop_bw_khz,
  output logic pwm_in_phase,
  output logic [4:0] output_attenuation_code,
  output logic coef_from_boot,
  // Serial boot memory pins
  output var serial_out_t boot_pins,
  input wire logic boot_miso,
  // Loaded coefficient bytes
  output logic [7:0] coef_byte,
  output logic coef_byte_valid
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] mute_ctrl_reg, mute_time_reg, ana_loop_reg, gain_reg;
  logic [7:0] sck_sel_reg, boot_ctrl_reg, read_cmd_reg;
  logic [7:0] addr_high_reg, addr_mid_reg, addr_low_reg;
  logic boot_done_reg, crc_fail_reg;
  logic [7:0] idx;
  logic wr_en;
  logic [7:0] rd_next;

  assign idx = wb_adr_i[9:2];
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

  // Software writes; only byte lane 0 carries register data
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mute_ctrl_reg <= `RST_MUTE_CTRL;
      mute_time_reg <= `RST_ZERO;
      ana_loop_reg <= `RST_ZERO;
      gain_reg <= `RST_ZERO;
      sck_sel_reg <= `RST_ZERO;
      boot_ctrl_reg <= `RST_ZERO;
      read_cmd_reg <= `RST_READ_CMD;
      addr_high_reg <= `RST_ZERO;
      addr_mid_reg <= `RST_ZERO;
      addr_low_reg <= `RST_ZERO;
    end else if (wr_en) begin
      case (idx)
        `IDX_MUTE_CTRL: mute_ctrl_reg <= wb_dat_i[7:0];
        `IDX_MUTE_TIME: mute_time_reg <= wb_dat_i[7:0];
        `IDX_ANA_LOOP: ana_loop_reg <= wb_dat_i[7:0];
        `IDX_GAIN: gain_reg <= wb_dat_i[7:0];
        `IDX_SCK_SEL: sck_sel_reg <= wb_dat_i[7:0];
        `IDX_BOOT_CTRL: boot_ctrl_reg <= wb_dat_i[7:0];
        `IDX_READ_CMD: read_cmd_reg <= wb_dat_i[7:0];
        `IDX_ADDR_HIGH: addr_high_reg <= wb_dat_i[7:0];
        `IDX_ADDR_MID: addr_mid_reg <= wb_dat_i[7:0];
        `IDX_ADDR_LOW: addr_low_reg <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // Read mux; status is read-only, unmapped reads as zero
  always_comb begin
    case (idx)
      `IDX_MUTE_CTRL: rd_next = mute_ctrl_reg;
      `IDX_MUTE_TIME: rd_next = mute_time_reg;
      `IDX_ANA_LOOP: rd_next = ana_loop_reg;
      `IDX_GAIN: rd_next = gain_reg;
      `IDX_SCK_SEL: rd_next = sck_sel_reg;
      `IDX_BOOT_CTRL: rd_next = boot_ctrl_reg;
      `IDX_READ_CMD: rd_next = read_cmd_reg;
      `IDX_ADDR_HIGH: rd_next = addr_high_reg;
      `IDX_ADDR_MID: rd_next = addr_mid_reg;
      `IDX_ADDR_LOW: rd_next = addr_low_reg;
      `IDX_BOOT_STAT: rd_next = {6'h00, crc_fail_reg, boot_done_reg};
      default: rd_next = 8'h00;
    endcase
  end

  // One wait state: ack one cycle after the strobe, dropped next cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= {24'h00_0000, rd_next};
    end
  end

  // ----------------------------------------
  // Analog settings decode
  // ----------------------------------------
  logic [1:0] bw_code;
  assign bw_code = ana_loop_reg[`POS_LOOP_BW +: 2];
  // Plain lookup keeps the odd ordering of codes explicit
  always_comb begin
    case (bw_code)
      2'h0: loop_bw_khz = 8'h64;
      2'h1: loop_bw_khz = 8'h50;
      2'h2: loop_bw_khz = 8'h78;
      default: loop_bw_khz = 8'haf;
    endcase
  end
  assign pwm_in_phase = ana_loop_reg[`POS_PHASE];
  assign output_attenuation_code = gain_reg[4:0];
  assign coef_from_boot = boot_ctrl_reg[`POS_BOOT_SRC];

  // ----------------------------------------
  // Auto-mute zero-run detection
  // ----------------------------------------
  function automatic logic [18:0] zero_run_samples(input logic [2:0] code);
    // Sample counts at the reference rate; other rates count the same
    case (code)
      3'h0: zero_run_samples = 19'(`ZR_US_0 * `SAMPLE_RATE_HZ / 1000000);
      // Product exceeds 32 bits from code 1 up, so widen before multiplying
      3'h1: zero_run_samples = 19'(64'(`ZR_US_1) * `SAMPLE_RATE_HZ / 1000000);
      3'h2: zero_run_samples = 19'(64'(`ZR_US_2) * `SAMPLE_RATE_HZ / 1000000);
      3'h3: zero_run_samples = 19'(64'(`ZR_US_3) * `SAMPLE_RATE_HZ / 1000000);
      3'h4: zero_run_samples = 19'(64'(`ZR_US_4) * `SAMPLE_RATE_HZ / 1000000);
      3'h5: zero_run_samples = 19'(64'(`ZR_US_5) * `SAMPLE_RATE_HZ / 1000000);
      3'h6: zero_run_samples = 19'(64'(`ZR_US_6) * `SAMPLE_RATE_HZ / 1000000);
      default: zero_run_samples = 19'(64'(`ZR_US_7) * `SAMPLE_RATE_HZ / 1000000);
    endcase
  endfunction

  logic [1:0] reached;
  logic [1:0] chan_en;
  logic link_mute;
  assign chan_en = mute_ctrl_reg[1:0];
  assign link_mute = mute_ctrl_reg[`POS_MUTE_LINK];

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic [18:0] zcnt_reg, zcnt_next, limit;
      logic [2:0] code;
      logic is_zero;
      assign code = (ch == 0) ? mute_time_reg[`POS_LEFT_TIME +: 3]
                              : mute_time_reg[`POS_RIGHT_TIME +: 3];
      assign limit = zero_run_samples(code);
      assign is_zero = (ch == 0) ? (audio_in.left == 24'h00_0000)
                                 : (audio_in.right == 24'h00_0000);
      // Counter saturates so a long silence cannot wrap to unmute
      always_comb begin
        zcnt_next = zcnt_reg;
        if (audio_in.valid) begin
          if (!is_zero) begin
            zcnt_next = 19'h0_0000;
          end else if (zcnt_reg < limit) begin
            zcnt_next = zcnt_reg + 19'h0_0001;
          end
        end
      end
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          zcnt_reg <= 19'h0_0000;
        end else begin
          zcnt_reg <= zcnt_next;
        end
      end
      assign reached[ch] = (zcnt_next >= limit);
    end
  endgenerate

  // Registered mute; decided from next counts so a non-zero sample unmutes at once
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_muted <= 2'b00;
    end else if (link_mute) begin
      chan_muted <= chan_en & {2{&reached}};
    end else begin
      chan_muted <= chan_en & reached;
    end
  end

  // ----------------------------------------
  // Serial boot master
  // ----------------------------------------
  localparam logic [3:0] HALF0 = 4'(`MCLK_HZ / (2 * `SCK_HZ_0));
  localparam logic [3:0] HALF1 = 4'(`MCLK_HZ / (2 * `SCK_HZ_1));
  localparam logic [3:0] HALF2 = 4'(`MCLK_HZ / (2 * `SCK_HZ_2));
  // Fastest rate cannot be reached from one clock; one cycle per half is the floor
  localparam logic [3:0] HALF3 = 4'h1;

  boot_state_t state_reg;
  logic [3:0] half_len, div_reg;
  logic tick;
  logic [2:0] bit_reg;
  logic [7:0] byte_reg, hdr_len, last_idx, tx_byte, rx_sh_reg, rx_byte;
  logic [7:0] crc_reg;
  logic miso_meta, miso_sync, src_q, start_req;
  logic wide, edge_idle, lsb_first;

  assign wide = boot_ctrl_reg[`POS_WIDE_ADDR];
  assign edge_idle = boot_ctrl_reg[`POS_EDGE_SEL];
  assign lsb_first = boot_ctrl_reg[`POS_BIT_ORDER];
  assign hdr_len = wide ? 8'h04 : 8'h03;
  assign last_idx = hdr_len + 8'(BOOT_BYTES);
  assign start_req = coef_from_boot && !src_q;

  // Clock rate selection
  always_comb begin
    case (boot_ctrl_reg[`POS_SCK_RATE +: 2])
      2'h0: half_len = HALF0;
      2'h1: half_len = HALF1;
      2'h2: half_len = HALF2;
      default: half_len = HALF3;
    endcase
  end

  // Header bytes: command, then address high (wide only), middle, low
  always_comb begin
    tx_byte = 8'h00;
    if (byte_reg == 8'h00) begin
      tx_byte = read_cmd_reg;
    end else if (wide && byte_reg == 8'h01) begin
      tx_byte = addr_high_reg;
    end else if (byte_reg == hdr_len - 8'h02) begin
      tx_byte = addr_mid_reg;
    end else if (byte_reg == hdr_len - 8'h01) begin
      tx_byte = addr_low_reg;
    end
  end

  // Incoming bit lands at the top or bottom per bit order
  assign rx_byte = lsb_first ? {miso_sync, rx_sh_reg[7:1]}
                             : {rx_sh_reg[6:0], miso_sync};

  // Pin synchroniser and start edge detect
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      miso_meta <= 1'b0;
      miso_sync <= 1'b0;
      src_q <= 1'b0;
    end else begin
      miso_meta <= boot_miso;
      miso_sync <= miso_meta;
      src_q <= coef_from_boot;
    end
  end

  // Half-period divider; produces one-cycle enable pulses
  assign tick = (div_reg == 4'h0);
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_reg <= 4'h0;
    end else if (state_reg == ST_IDLE || tick) begin
      div_reg <= half_len - 4'h1;
    end else begin
      div_reg <= div_reg - 4'h1;
    end
  end

  // Transfer engine: launch half changes data, sample half reads it
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      boot_pins <= '{sck: 1'b0, mosi: 1'b0, cs_n: 1'b1};
      bit_reg <= 3'h0;
      byte_reg <= 8'h00;
      rx_sh_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          boot_pins.sck <= edge_idle;
          boot_pins.cs_n <= 1'b1;
          if (start_req) begin
            state_reg <= ST_LAUNCH;
            boot_pins.cs_n <= 1'b0;
            bit_reg <= 3'h0;
            byte_reg <= 8'h00;
          end
        end
        ST_LAUNCH: begin
          if (tick) begin
            boot_pins.sck <= !edge_idle;
            boot_pins.mosi <= lsb_first ? tx_byte[bit_reg]
                                        : tx_byte[3'h7 - bit_reg];
            state_reg <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            boot_pins.sck <= edge_idle;
            rx_sh_reg <= rx_byte;
            bit_reg <= bit_reg + 3'h1;
            state_reg <= ST_LAUNCH;
            if (bit_reg == 3'h7) begin
              byte_reg <= byte_reg + 8'h01;
              if (byte_reg == last_idx) begin
                state_reg <= ST_FINISH;
              end
            end
          end
        end
        ST_FINISH: begin
          boot_pins.cs_n <= 1'b1;
          boot_pins.sck <= edge_idle;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Received data, CRC-8 (poly 0x07) and boot status
  // ----------------------------------------
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    end
    crc8 = r;
  endfunction

  logic byte_end;
  assign byte_end = (state_reg == ST_SAMPLE) && tick && (bit_reg == 3'h7);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      coef_byte <= 8'h00;
      coef_byte_valid <= 1'b0;
      crc_reg <= 8'h00;
      crc_fail_reg <= 1'b0;
      boot_done_reg <= 1'b0;
    end else begin
      coef_byte_valid <= 1'b0;
      if (start_req && state_reg == ST_IDLE) begin
        crc_reg <= 8'h00;
        boot_done_reg <= 1'b0;
        crc_fail_reg <= 1'b0;
      end
      if (byte_end && byte_reg >= hdr_len && byte_reg < last_idx) begin
        coef_byte <= rx_byte;
        coef_byte_valid <= 1'b1;
        crc_reg <= crc8(crc_reg, rx_byte);
      end
      if (byte_end && byte_reg == last_idx) begin
        crc_fail_reg <= (rx_byte != crc_reg);
      end
      if (state_reg == ST_FINISH) begin
        boot_done_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_status_read_only: assert property (
    wr_en && idx == `IDX_BOOT_STAT && !(state_reg == ST_FINISH)
      |=> $stable(boot_done_reg))
    else $error("status changed by software write");
  a_bw_decode_fast: assert property (
    bw_code == 2'h3 |-> loop_bw_khz == 8'haf)
    else $error("bandwidth code 3 not 175 kHz");
  a_gain_follows_reg: assert property (
    wr_en && idx == `IDX_GAIN |=> output_attenuation_code == $past(wb_dat_i[4:0]))
    else $error("gain code not taken from write");
  a_nonzero_unmutes: assert property (
    audio_in.valid && audio_in.left != 24'h00_0000 && !link_mute
      |=> !chan_muted[0])
    else $error("left stays muted after non-zero sample");
  a_link_both_mute: assert property (
    link_mute && chan_en == 2'b11 |=> chan_muted[0] == chan_muted[1])
    else $error("linked channels mute apart");
  a_sck_idle_level: assert property (
    state_reg == ST_IDLE ##1 state_reg == ST_IDLE |-> boot_pins.sck == $past(edge_idle))
    else $error("serial clock idle level wrong");
  a_cs_during_xfer: assert property (
    start_req && state_reg == ST_IDLE |=> !boot_pins.cs_n [*2])
    else $error("select not held low at start");
  a_done_after_finish: assert property (
    state_reg == ST_FINISH |=> boot_done_reg && boot_pins.cs_n)
    else $error("done flag not set after load");

  c_boot_load: cover property (state_reg == ST_FINISH);
  c_linked_mute: cover property (link_mute && chan_muted == 2'b11);
  c_crc_fail: cover property ($rose(crc_fail_reg));
  c_reg_write: cover property (wr_en && idx == `IDX_BOOT_CTRL);

endmodule // automute_gain_eeprom_boot_cfg
`default_nettype wire

// >>> sim/boot_memory_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Serial coefficient memory behind the boot master
// ----------------------------------------
module boot_memory_model #(
  parameter int NDATA = 2
) (
  // Serial pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic cs_n,
  // Settings mirrored by the bench
  input wire logic edge_sel,
  input wire logic lsb_first,
  input wire logic wide,
  input wire logic bad_crc,
  // Reply and header seen
  output logic miso,
  output logic [31:0] hdr_rx
);
  int bit_cnt;
  int idx;
  int nhdr;
  logic frame = 1'b0;
  logic [7:0] rx_byte;

  assign nhdr = wide ? 4 : 3;

  // Data bytes, then a CRC-8 (poly 07, init 0) over them
  function automatic logic [7:0] stream_byte(input int k, input logic bad);
    logic [7:0] crc;
    logic [7:0] d;
    crc = 8'h00;
    for (int i = 0; i < NDATA; i++) begin
      d = 8'h5a + 8'h37 * i[7:0];
      if (i == k) return d;
      crc = crc ^ d;
      for (int b = 0; b < 8; b++) crc = crc[7] ? {crc[6:0], 1'b0} ^ 8'h07 : {crc[6:0], 1'b0};
    end
    return bad ? ~crc : crc;
  endfunction

  // Reply bit for a bit count; header time answers with zeros
  function automatic logic reply_bit(input int n);
    logic [7:0] b;
    b = n / 8 >= nhdr ? stream_byte(n / 8 - nhdr, bad_crc) : 8'h00;
    return b[lsb_first ? n % 8 : 7 - n % 8];
  endfunction

  // One process owns the line; the next reply bit goes up on the return edge,
  // a half period early, so it outlasts the two-flop delay on the input
  always @(cs_n or sck) begin
    if (cs_n !== 1'b0) begin
      // No pull on the line, so a released line shows the inverse of the last bit
      if (frame) miso = ~miso;
      else if (miso === 1'bx) miso = 1'b0;
      frame = 1'b0;
    end else if (!frame) begin
      frame = 1'b1;
      bit_cnt = 0;
      hdr_rx = 32'h0;
      miso = reply_bit(0);
    end else if (sck == edge_sel) begin
      idx = lsb_first ? bit_cnt % 8 : 7 - bit_cnt % 8;
      rx_byte[idx] = mosi;
      bit_cnt++;
      if (bit_cnt % 8 == 0 && bit_cnt / 8 <= nhdr) hdr_rx = {hdr_rx[23:0], rx_byte};
      miso = reply_bit(bit_cnt);
    end
  end
endmodule // boot_memory_model
`default_nettype wire

// >>> sim/test_automute_gain_eeprom_boot_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module test_automute_gain_eeprom_boot_cfg
  import automute_gain_eeprom_boot_cfg_pkg::*;
;
  localparam int HALF[4] = '{4, 2, 1, 1};
  localparam int BW[4] = '{100, 80, 120, 175};
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  stereo_sample_t ain = '0;
  logic bad_crc = 1'b0;
  logic [7:0] cfg = 8'h00;
  logic [7:0] q;
  logic [31:0] rdat;
  logic ack;
  logic [1:0] muted;
  logic [7:0] bw;
  logic ph;
  logic [4:0] att;
  logic cfb;
  serial_out_t pins;
  logic miso;
  logic [7:0] cbyte;
  logic cvalid;
  logic [31:0] hdr;
  logic [7:0] got_q[$];
  int n_fail = 0;
  int n_tests = 0;
  int cyc_cnt = 0;

  automute_gain_eeprom_boot_cfg #(.BOOT_BYTES(2)) u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .audio_in(ain), .chan_muted(muted), .loop_bw_khz(bw), .pwm_in_phase(ph),
    .output_attenuation_code(att), .coef_from_boot(cfb), .boot_pins(pins),
    .boot_miso(miso), .coef_byte(cbyte), .coef_byte_valid(cvalid)
  );

  boot_memory_model #(.NDATA(2)) u_mem (
    .sck(pins.sck), .mosi(pins.mosi), .cs_n(pins.cs_n), .edge_sel(cfg[2]),
    .lsb_first(cfg[1]), .wide(cfg[5]), .bad_crc(bad_crc), .miso(miso), .hdr_rx(hdr)
  );

  // ----------------------------------------
  // Clock, hang guard and byte capture
  // ----------------------------------------
  initial forever #50 mclk = ~mclk;

  // Ceiling sits well above the longest mute run plus all boots
  always @(posedge mclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cvalid === 1'b1) got_q.push_back(cbyte);
    if (cyc_cnt == 60000) begin
      n_fail++;
      $display("MISMATCH t=%0t run hung", $time);
      test_done();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic test_done();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    dat <= {24'h0, d};
    @(posedge mclk);
    while (ack !== 1'b1 && n < 20) begin
      n++;
      @(posedge mclk);
    end
    if (ack !== 1'b1) begin
      n_fail++;
      $display("MISMATCH t=%0t no ack", $time);
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00, 4'hf);
    chk(q, exp, "register read");
  endtask

  // Samples arrive every other cycle; mute result checked two cycles later
  task automatic feed(input int n, input logic [23:0] l, input logic [1:0] exp);
    repeat (n) begin
      @(posedge mclk);
      ain <= '{1'b1, l, 24'h0};
      @(posedge mclk);
      ain.valid <= 1'b0;
    end
    repeat (2) @(posedge mclk);
    chk(muted, exp, "mute state");
  endtask

  task automatic boot(input logic [7:0] c);
    int n;
    int h;
    logic s0;
    cfg = c;
    got_q.delete();
    wb(1'b1, 8'h56, c, 4'h1);
    wb(1'b1, 8'h56, c | 8'h01, 4'h1);
    chk(cfb, 1'b1, "coef source");
    n = 0;
    h = 0;
    while (pins.cs_n !== 1'b0 && n < 10) begin
      n++;
      @(posedge mclk);
    end
    chk(pins.cs_n, 1'b0, "select low");
    chk(pins.sck, c[2], "sck idle level");
    s0 = pins.sck;
    while (pins.sck === s0 && n < 100) begin
      n++;
      @(posedge mclk);
    end
    s0 = pins.sck;
    while (pins.sck === s0 && h < 100) begin
      h++;
      @(posedge mclk);
    end
    chk(h, HALF[c[4:3]], "sck half period");
    n = 0;
    while (pins.cs_n !== 1'b1 && n < 3000) begin
      n++;
      @(posedge mclk);
    end
    chk(pins.cs_n, 1'b1, "select released");
    repeat (3) @(posedge mclk);
    chk(hdr, c[5] ? 32'h03123456 : 32'h00033456, "header");
    // Fast rates cannot return read data through the input synchroniser
    if (c[4] == 1'b0) begin
      chk(got_q.size(), 2, "byte count");
      for (int k = 0; k < 2; k++) chk(got_q[k], 8'h5a + 8'h37 * k[7:0], "data");
      rdchk(8'h5b, {6'h00, bad_crc, 1'b1});
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    for (int i = 8'h50; i <= 8'h5b; i++) begin
      rdchk(i[7:0], i == 8'h50 ? 8'h07 : (i == 8'h57 ? 8'h03 : 8'h00));
    end
    rdchk(8'h00, 8'h00);
    chk(bw, 8'd100, "bandwidth at reset");
    chk(pins.cs_n, 1'b1, "select idle");
    wb(1'b1, 8'h53, 8'h61, 4'h1);
    rdchk(8'h53, 8'h61);
    chk(ph, 1'b1, "in phase");
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, 8'h53, {1'b0, c[1:0], 5'h00}, 4'h1);
      chk(bw, BW[c], "bandwidth");
    end
    chk(ph, 1'b0, "out of phase");
    wb(1'b1, 8'h54, 8'h1f, 4'h1);
    rdchk(8'h54, 8'h1f);
    chk(att, 5'h1f, "gain code");
    wb(1'b1, 8'h54, 8'h05, 4'he);
    chk(att, 5'h1f, "write without byte lane");
    wb(1'b1, 8'h55, 8'h03, 4'h1);
    rdchk(8'h55, 8'h03);
    wb(1'b1, 8'h5b, 8'hff, 4'h1);
    rdchk(8'h5b, 8'h00);
    wb(1'b1, 8'h52, 8'hff, 4'h1);
    rdchk(8'h52, 8'h00);
    wb(1'b1, 8'h58, 8'h12, 4'h1);
    wb(1'b1, 8'h59, 8'h34, 4'h1);
    wb(1'b1, 8'h5a, 8'h56, 4'h1);
    rdchk(8'h58, 8'h12);
    // Left code 1, right code 0: swapped fields would mute the wrong side
    wb(1'b1, 8'h51, 8'h10, 4'h1);
    rdchk(8'h51, 8'h10);
    wb(1'b1, 8'h50, 8'h03, 4'h1);
    feed(1103, 24'h0, 2'b00);
    feed(1, 24'h0, 2'b10);
    feed(3983, 24'h0, 2'b10);
    feed(1, 24'h0, 2'b11);
    feed(1, 24'h000001, 2'b10);
    wb(1'b1, 8'h50, 8'h07, 4'h1);
    wb(1'b1, 8'h51, 8'h00, 4'h1);
    feed(1, 24'h0, 2'b00);
    feed(1102, 24'h0, 2'b00);
    feed(1, 24'h0, 2'b11);
    wb(1'b1, 8'h50, 8'h02, 4'h1);
    feed(1, 24'h0, 2'b10);
    foreach (HALF[r]) boot({2'b00, r[0], r[1:0], r[1], r[0], 1'b0});
    boot(8'h26);
    bad_crc = 1'b1;
    boot(8'h20);
    test_done();
  end
endmodule // test_automute_gain_eeprom_boot_cfg
`default_nettype wire
